/* core/bscan_defs.svh */
`ifndef BSCAN_DEFS_SVH
`define BSCAN_DEFS_SVH

// Instruction register
`define IR_LEN 6
`define IR_SET_TESTMODE 6'h20
`define IR_SAMPLE_PRELOAD 6'h3d
`define IR_EXTEST 6'h3e
`define IR_BYPASS 6'h3f
`define IR_CAPTURE_VAL 6'h01

// Boundary register and its default split into input and output cells
`define BSR_LEN 317
`define BSR_IN_CELLS 159
`define BSR_OUT_CELLS 158

// Test-mode register
`define MODE_LEN 2
`define MODE_OFF 2'h0
`define MODE_BSCAN 2'h3

// Synchroniser depth
`define SYNC_STAGES 2

`endif

/* core/bscan_pkg.sv */
package bscan_pkg;

	// Test access port controller states
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SH_DR = 4'h4,
		TAP_EX1_DR = 4'h5,
		TAP_PA_DR = 4'h6,
		TAP_EX2_DR = 4'h7,
		TAP_UP_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'ha,
		TAP_SH_IR = 4'hb,
		TAP_EX1_IR = 4'hc,
		TAP_PA_IR = 4'hd,
		TAP_EX2_IR = 4'he,
		TAP_UP_IR = 4'hf
	} tap_state_t;

endpackage : bscan_pkg

/* core/bscan_sync.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bscan_defs.svh"

// Two-stage level synchroniser; the first stage feeds only the second
module bscan_sync #(
	parameter int W = 1
) (
	// Clock and reset of the receiving domain
	input wire logic clk,
	input wire logic rst,
	// Level from the far domain and its safe copy
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] q_d;

	generate
		if (W < 1) begin : g_bad_width
			$error("bscan_sync width must be at least one");
		end
	endgenerate

	// Next values of both stages
	always_comb begin
		meta_d = rst ? '0 : d;
		q_d = rst ? '0 : meta_q;
	end

	// Stage registers
	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		q <= q_d;
	end

endmodule : bscan_sync

`default_nettype wire

/* core/bscan_top.sv */
// Functional notes
// - Sample records all pin states without disturbing pins or core.
// - Sampled states enter boundary cells on rising test clock in Capture-DR.
// - Preload shifts a pattern into cells without reaching core logic.
// - Instruction 0x3d shifts 317 bits: preload in, sample out.
// - External test drives output-cell values onto output pins.
// - External test captures levels arriving at input pins.
// - Instruction 0x3e shifts 317 bits; input ignored, contents shifted out.
// - Boundary register is exactly 317 cells long.
// - Mode 00 disables test, 11 selects boundary scan; others reserved.
`timescale 1ns/1ns
`default_nettype none
`include "bscan_defs.svh"

module bscan_top import bscan_pkg::*; #(
	parameter int IN_CELLS = `BSR_IN_CELLS,
	parameter int OUT_CELLS = `BSR_OUT_CELLS
) (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Test access port
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	// Core side
	input wire logic [OUT_CELLS-1:0] core_out,
	output logic [IN_CELLS-1:0] core_in,
	// Pin side
	input wire logic [IN_CELLS-1:0] pin_in,
	output logic [OUT_CELLS-1:0] pin_out
);

	localparam int L = `BSR_LEN;

	generate
		if (IN_CELLS + OUT_CELLS != `BSR_LEN || IN_CELLS < 1 || OUT_CELLS < 1) begin : g_bad
			$error("boundary cell split must total the boundary length");
		end
	endgenerate

	// Next TAP state from the present one and the mode select
	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		case (s)
			TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UP_DR : TAP_PA_DR;
			TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UP_DR : TAP_SH_DR;
			TAP_UP_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UP_IR : TAP_PA_IR;
			TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UP_IR : TAP_SH_IR;
			TAP_UP_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction : tap_next

	// ---------------- Test clock domain ----------------
	logic rst_t;
	logic [IN_CELLS-1:0] pin_in_t;
	logic [OUT_CELLS-1:0] core_out_t;
	tap_state_t tap_q, tap_d;
	logic [`IR_LEN-1:0] ir_q, ir_d, ir_sr_q, ir_sr_d;
	logic [`MODE_LEN-1:0] mode_q, mode_d, mode_sr_q, mode_sr_d;
	logic [L-1:0] bsr_q, bsr_d;
	logic byp_q, byp_d;
	logic [OUT_CELLS-1:0] upd_q, upd_d;
	logic ext_t_q, ext_t_d;
	logic tog_q, tog_d;
	logic tdo_d, tdo_oe_n_d;

	// Reset, pins and core outputs reach the test clock through synchronisers
	bscan_sync #(.W(1)) u_rst_t (.clk(tck), .rst(1'b0), .d(rst), .q(rst_t));
	bscan_sync #(.W(IN_CELLS)) u_pin_t (.clk(tck), .rst(rst_t), .d(pin_in), .q(pin_in_t));
	bscan_sync #(.W(OUT_CELLS)) u_core_t (.clk(tck), .rst(rst_t), .d(core_out), .q(core_out_t));

	// TAP, instruction, data registers and the handover word for the system side
	always_comb begin
		tap_d = tap_next(tap_q, tms);
		ir_d = ir_q;
		ir_sr_d = ir_sr_q;
		mode_d = mode_q;
		mode_sr_d = mode_sr_q;
		bsr_d = bsr_q;
		byp_d = byp_q;
		upd_d = upd_q;
		case (tap_q)
			TAP_RESET: begin
				ir_d = `IR_BYPASS;
			end
			TAP_CAP_IR: begin
				ir_sr_d = `IR_CAPTURE_VAL;
			end
			TAP_SH_IR: begin
				ir_sr_d = {tdi, ir_sr_q[`IR_LEN-1:1]};
			end
			TAP_UP_IR: begin
				ir_d = ir_sr_q;
			end
			TAP_CAP_DR: begin
				if (ir_q == `IR_SAMPLE_PRELOAD) begin
					bsr_d = {core_out_t, pin_in_t};
				end else if (ir_q == `IR_EXTEST) begin
					bsr_d[IN_CELLS-1:0] = pin_in_t;
				end else if (ir_q == `IR_SET_TESTMODE) begin
					mode_sr_d = mode_q;
				end else begin
					byp_d = 1'b0;
				end
			end
			TAP_SH_DR: begin
				if (ir_q == `IR_SAMPLE_PRELOAD) begin
					bsr_d = {tdi, bsr_q[L-1:1]};
				end else if (ir_q == `IR_EXTEST) begin
					bsr_d = {bsr_q[0], bsr_q[L-1:1]};
				end else if (ir_q == `IR_SET_TESTMODE) begin
					mode_sr_d = {tdi, mode_sr_q[`MODE_LEN-1:1]};
				end else begin
					byp_d = tdi;
				end
			end
			TAP_UP_DR: begin
				// Preload only fills the update stage; it reaches pins under external test
				if (ir_q == `IR_SAMPLE_PRELOAD) begin
					upd_d = bsr_q[L-1:IN_CELLS];
				end else if (ir_q == `IR_SET_TESTMODE) begin
					mode_d = mode_sr_q;
				end
			end
			default: begin
			end
		endcase
		if (rst_t) begin
			tap_d = TAP_RESET;
			ir_d = `IR_BYPASS;
			ir_sr_d = '0;
			mode_d = `MODE_OFF;
			mode_sr_d = '0;
			bsr_d = '0;
			byp_d = 1'b0;
			upd_d = '0;
		end
		// Pins follow the cells only with the test instruction and boundary-scan mode
		// Next values are used: the test clock may stop right after an update
		ext_t_d = (ir_d == `IR_EXTEST) && (mode_d == `MODE_BSCAN);
		// Toggle flags a new handover word; word is held steady until the next toggle
		tog_d = tog_q ^ ((ext_t_d != ext_t_q) || (upd_d != upd_q));
	end

	// Test clock registers
	always_ff @(posedge tck) begin
		tap_q <= tap_d;
		ir_q <= ir_d;
		ir_sr_q <= ir_sr_d;
		mode_q <= mode_d;
		mode_sr_q <= mode_sr_d;
		bsr_q <= bsr_d;
		byp_q <= byp_d;
		upd_q <= upd_d;
		ext_t_q <= rst_t ? 1'b0 : ext_t_d;
		tog_q <= rst_t ? 1'b0 : tog_d;
	end

	// Serial output changes on the falling edge so the tester samples it mid-bit
	always_comb begin
		tdo_d = 1'b0;
		tdo_oe_n_d = 1'b1;
		if (tap_q == TAP_SH_IR) begin
			tdo_d = ir_sr_q[0];
			tdo_oe_n_d = 1'b0;
		end else if (tap_q == TAP_SH_DR) begin
			tdo_oe_n_d = 1'b0;
			if (ir_q == `IR_SAMPLE_PRELOAD || ir_q == `IR_EXTEST) begin
				tdo_d = bsr_q[0];
			end else if (ir_q == `IR_SET_TESTMODE) begin
				tdo_d = mode_sr_q[0];
			end else begin
				tdo_d = byp_q;
			end
		end
		if (rst_t) begin
			tdo_d = 1'b0;
			tdo_oe_n_d = 1'b1;
		end
	end

	always_ff @(negedge tck) begin
		tdo <= tdo_d;
		tdo_oe_n <= tdo_oe_n_d;
	end

	// ---------------- System clock domain ----------------
	logic tog_c;
	logic seen_q, seen_d;
	logic ext_c_q, ext_c_d;
	logic [OUT_CELLS-1:0] upd_c_q, upd_c_d;
	logic [IN_CELLS-1:0] pin_in_c;
	logic [IN_CELLS-1:0] core_in_d;
	logic [OUT_CELLS-1:0] pin_out_d;

	bscan_sync #(.W(1)) u_tog_c (.clk(clk), .rst(rst), .d(tog_q), .q(tog_c));
	bscan_sync #(.W(IN_CELLS)) u_pin_c (.clk(clk), .rst(rst), .d(pin_in), .q(pin_in_c));

	// Take the handover word once its toggle has settled on this side
	always_comb begin
		seen_d = tog_c;
		ext_c_d = ext_c_q;
		upd_c_d = upd_c_q;
		if (tog_c != seen_q) begin
			ext_c_d = ext_t_q;
			upd_c_d = upd_q;
		end
		// Core always sees the real pins, so preload never disturbs it
		core_in_d = pin_in_c;
		pin_out_d = ext_c_q ? upd_c_q : core_out;
		if (rst) begin
			seen_d = 1'b0;
			ext_c_d = 1'b0;
			upd_c_d = '0;
			core_in_d = '0;
			pin_out_d = '0;
		end
	end

	// System clock registers
	always_ff @(posedge clk) begin
		seen_q <= seen_d;
		ext_c_q <= ext_c_d;
		upd_c_q <= upd_c_d;
		core_in <= core_in_d;
		pin_out <= pin_out_d;
	end

	// ---------------- Checks ----------------
	sequence s_cap(logic [`IR_LEN-1:0] code);
		tap_q == TAP_CAP_DR && ir_q == code && !rst_t;
	endsequence

	sequence s_shift(logic [`IR_LEN-1:0] code);
		tap_q == TAP_SH_DR && ir_q == code && !rst_t;
	endsequence

	property p_sample_capture;
		@(posedge tck) disable iff (rst_t)
		s_cap(`IR_SAMPLE_PRELOAD) |=> bsr_q == {$past(core_out_t), $past(pin_in_t)};
	endproperty
	a_sample_capture: assert property (p_sample_capture) else $error("sample capture wrong");

	property p_core_unaffected;
		@(posedge clk) disable iff (rst)
		!$past(rst) |-> core_in == $past(pin_in_c);
	endproperty
	a_core_unaffected: assert property (p_core_unaffected) else $error("core input disturbed");

	property p_preload_shift;
		@(posedge tck) disable iff (rst_t)
		s_shift(`IR_SAMPLE_PRELOAD) |=> bsr_q[L-1] == $past(tdi) && bsr_q[L-2:0] == $past(bsr_q[L-1:1]);
	endproperty
	a_preload_shift: assert property (p_preload_shift) else $error("preload shift wrong");

	property p_ext_drive;
		@(posedge clk) disable iff (rst)
		ext_c_q ##1 !rst |-> pin_out == $past(upd_c_q);
	endproperty
	a_ext_drive: assert property (p_ext_drive) else $error("pins not driven by cells");

	property p_ext_capture;
		@(posedge tck) disable iff (rst_t)
		s_cap(`IR_EXTEST) |=> bsr_q[IN_CELLS-1:0] == $past(pin_in_t) && $stable(bsr_q[L-1:IN_CELLS]);
	endproperty
	a_ext_capture: assert property (p_ext_capture) else $error("input cell capture wrong");

	property p_ext_ignore_tdi;
		@(posedge tck) disable iff (rst_t)
		s_shift(`IR_EXTEST) |=> bsr_q == {$past(bsr_q[0]), $past(bsr_q[L-1:1])} && $stable(upd_q);
	endproperty
	a_ext_ignore_tdi: assert property (p_ext_ignore_tdi) else $error("shift-in not ignored");

	property p_mode_load;
		@(posedge tck) disable iff (rst_t)
		tap_q == TAP_UP_DR && ir_q == `IR_SET_TESTMODE |=> mode_q == $past(mode_sr_q);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

	property p_ext_gate;
		@(posedge tck) disable iff (rst_t)
		ext_t_q |-> ir_q == `IR_EXTEST && mode_q == `MODE_BSCAN;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("test drive not gated by mode");

	property p_normal_pins;
		@(posedge clk) disable iff (rst)
		!ext_c_q ##1 !rst |-> pin_out == $past(core_out);
	endproperty
	a_normal_pins: assert property (p_normal_pins) else $error("pins left core control");

endmodule : bscan_top

`default_nettype wire

/* test/jtag_tester.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bscan_defs.svh"

// Tester at the far side; the test clock stands low outside frames
module jtag_tester (
	// Test access port
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// Drive after the falling edge, take tdo at the rising edge
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#32 tck = 1'b1;
		o = tdo;
		#32 tck = 1'b0;
	endtask : tick

	// Five ones reach reset from any state, then park in idle
	task automatic tlr();
		logic o;
		for (int i = 0; i < 6; i++) begin
			tick(i < 5, 1'b0, o);
		end
	endtask : tlr

	// Whole scan from idle back to idle, bit 0 first
	task automatic shift(input logic ir, input int n, input logic [324:0] din,
			output logic [324:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (ir) begin
			tick(1'b1, 1'b0, o);
		end
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask : shift

	// Test mode is loaded by its instruction, then a two-bit data scan
	task automatic set_mode(input logic [1:0] m);
		logic [324:0] o;
		shift(1'b1, `IR_LEN, 325'(`IR_SET_TESTMODE), o);
		shift(1'b0, `MODE_LEN, 325'(m), o);
	endtask : set_mode
endmodule : jtag_tester
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bscan_defs.svh"

module testbench;
	localparam int IC = `BSR_IN_CELLS;
	localparam int OC = `BSR_OUT_CELLS;
	logic clk, rst, tck, tms, tdi, tdo, tdo_oe_n;
	logic [OC-1:0] core_out, pin_out;
	logic [IC-1:0] core_in, pin_in;
	logic [324:0] dout;
	logic [316:0] pre;
	int errors, cmp_count;

	bscan_top #(.IN_CELLS(IC), .OUT_CELLS(OC)) i_dut (.clk(clk), .rst(rst), .tck(tck),
		.tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .core_out(core_out),
		.core_in(core_in), .pin_in(pin_in), .pin_out(pin_out));
	jtag_tester i_jtag (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// System clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Shared compare
	task automatic chk(input logic [324:0] got, input logic [324:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic give_verdict();
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict

	// Snapshot, exact length, then a clean preload that must stay off core and pins
	task automatic t_sample_preload();
		pre = {{79{2'b01}}, {53{3'b100}}};
		i_jtag.shift(1'b1, `IR_LEN, 325'(`IR_SAMPLE_PRELOAD), dout);
		i_jtag.shift(1'b0, 325, {8'h00, pre}, dout);
		chk(325'(dout[316:0]), 325'({core_out, pin_in}));
		chk(325'(dout[324:317]), 325'(pre[7:0]));
		i_jtag.shift(1'b0, `BSR_LEN, 325'(pre), dout);
		settle(12);
		chk(325'(pin_out), 325'(core_out));
		chk(325'(core_in), 325'(pin_in));
	endtask : t_sample_preload

	// Every mode code: only boundary-scan mode hands pins to the cells
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			i_jtag.set_mode(2'(m));
			i_jtag.shift(1'b1, `IR_LEN, 325'(`IR_EXTEST), dout);
			settle(12);
			chk(325'(pin_out), 325'(m == 3 ? pre[316:IC] : core_out));
		end
	endtask : t_modes

	// Input cells capture the pins, output cells hold, scan-in ignored
	task automatic t_extest();
		@(posedge clk);
		pin_in <= ~pin_in;
		core_out <= ~core_out;
		settle(8);
		i_jtag.shift(1'b0, `BSR_LEN, '1, dout);
		chk(325'(dout[316:0]), 325'({pre[316:IC], pin_in}));
		settle(12);
		chk(325'(pin_out), 325'(pre[316:IC]));
		chk(325'(tdo_oe_n), 325'(1'b1));
		i_jtag.set_mode(2'h0);
		settle(12);
		chk(325'(pin_out), 325'(core_out));
	endtask : t_extest

	// Main sequence; the test clock must run while reset is held
	initial begin
		errors = 0;
		cmp_count = 0;
		rst = 1'b1;
		core_out = {79{2'b10}};
		pin_in = {53{3'b011}};
		fork
			repeat (8) @(posedge clk);
			i_jtag.tlr();
		join
		#1;
		chk(325'({pin_out, core_in}), 325'(0));
		@(posedge clk);
		rst <= 1'b0;
		i_jtag.tlr();
		settle(6);
		chk(325'(pin_out), 325'(core_out));
		chk(325'(core_in), 325'(pin_in));
		t_sample_preload();
		t_modes();
		t_extest();
		give_verdict();
	end

	// Scans take well under half a millisecond
	initial begin
		#1000000;
		errors++;
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
